/* File: spi_far_end.sv */
// far end model: a mode-0 slave answering the port, or a master driving it
// assumes the bench resolves the shared wires from all enables
`timescale 1ns/100ps
`default_nettype none
module spi_far_end
(
    // resolved wires
    input wire logic selN,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso,
    // far end drives, select high means released to the pull-up
    output logic sOut,
    output logic mSelN,
    output logic mSclk,
    output logic mMosi
);
    logic [7:0] txByte = 8'h00;
    logic [7:0] sh;
    logic [7:0] rxByte;
    // idle levels
    initial
    begin
        {sOut, mSelN, mSclk, mMosi} = 4'h4;
    end
    // slave: msb ready at select fall
    always @(negedge selN)
    begin
        sh = txByte;
        sOut = sh[7];
    end
    // slave: next bit on each falling clock
    always @(negedge sclk)
    begin
        if (!selN && mSelN)
        begin
            sh = sh << 1;
            sOut = sh[7];
        end
    end
    // released line shows the inverse of its last value
    always @(posedge selN)
        sOut = ~sOut;
    // both roles sample on the rising clock
    always @(posedge sclk)
        if (!selN)
            rxByte = {rxByte[6:0], mSelN ? mosi : miso};
    // master: select low, eight clocks of 160 ns, msb first, then release
    task automatic xfer(input logic [7:0] b);
        #3 mSelN = 1'b0;
        #160;
        for (int i = 7; i >= 0; i--)
        begin
            mMosi = b[i];
            #80 mSclk = 1'b1;
            #80 mSclk = 1'b0;
        end
        #80 mSelN = 1'b1;
        mMosi = ~mMosi;
    endtask
endmodule // spi_far_end
`default_nettype wire

/* File: spi_fault_checker.sv */
// concurrent checks on the ports of the select, fault and error logic
// assumes one mclk domain and an active-high asynchronous reset
`timescale 1ns/100ps
`default_nettype none
module spi_fault_checker
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // requests and enables
    input wire logic dataWr,
    input wire logic clrDone,
    input wire logic serialIrqEnable,
    input wire logic globalIrqEnable,
    // state and pins
    input wire logic masterSelect_ff,
    input wire logic portEnable_ff,
    input wire logic faultDetectDisable_ff,
    input wire logic selectOutputEnable_ff,
    input wire logic [7:0] serialStatusReg,
    input wire logic [7:0] readBuf_ff,
    input wire logic irq_ff,
    input wire logic selectNOut_ff,
    input wire logic selectNOeN_ff,
    input wire logic sclkOut_ff
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // select may be driven only as master with detection off and output on
    wire logic selFree = !masterSelect_ff || !faultDetectDisable_ff || !selectOutputEnable_ff;
    // collision flag never asks for service
    wire logic irqCause = (serialStatusReg[7] || serialStatusReg[5] || serialStatusReg[4])
        && serialIrqEnable && globalIrqEnable;
    AST_SEL_INPUT: assert property (selFree && $past(selFree) |-> selectNOeN_ff)
        else $error("select pin driven when it must be an input");
    AST_SEL_IDLE: assert property (!selectNOeN_ff && selectNOut_ff |-> !sclkOut_ff)
        else $error("serial clock runs while slave deselected");
    AST_FAULT: assert property ($rose(serialStatusReg[4]) |->
        !masterSelect_ff && !portEnable_ff && $past(masterSelect_ff) && $past(portEnable_ff)
        && !$past(faultDetectDisable_ff))
        else $error("mode fault without cause or without disabling");
    AST_ABORT: assert property ($rose(serialStatusReg[4]) |-> (!sclkOut_ff) [*8])
        else $error("serial clock active after mode fault");
    AST_COLLIDE: assert property ($rose(serialStatusReg[6]) |-> $past(dataWr))
        else $error("collision flag without data write");
    AST_DONE_HOLD: assert property (serialStatusReg[7] && !clrDone |=> serialStatusReg[7])
        else $error("done flag dropped without clear");
    AST_OVR_KEEP: assert property ($rose(serialStatusReg[5]) |-> $stable(readBuf_ff))
        else $error("read buffer changed on overrun");
    AST_BUF_DONE: assert property (!$stable(readBuf_ff) |-> $rose(serialStatusReg[7]))
        else $error("read buffer changed without done flag");
    AST_IRQ: assert property (irq_ff == $past(irqCause))
        else $error("request does not follow enabled flags");
    // main scenarios reached
    COV_DONE: cover property ($rose(serialStatusReg[7]));
    COV_FAULT: cover property ($rose(serialStatusReg[4]));
    COV_OVR: cover property ($rose(serialStatusReg[5]));
    COV_COLL: cover property ($rose(serialStatusReg[6]));
endmodule // spi_fault_checker
////////////////////////////////////////////////////////////////////////////////
bind spi_select_fault spi_fault_checker u_checker
(
    .mclk, .sys_rst, .dataWr, .clrDone, .serialIrqEnable, .globalIrqEnable, .masterSelect_ff,
    .portEnable_ff, .faultDetectDisable_ff, .selectOutputEnable_ff, .serialStatusReg,
    .readBuf_ff, .irq_ff, .selectNOut_ff, .selectNOeN_ff, .sclkOut_ff
);
`default_nettype wire

/* File: spi_fault_map.vh */
// constants for the select, fault and error logic of the byte-wide serial port
// assumes a 100 MHz system clock; included by spi_select_fault.v
`ifndef SPI_FAULT_MAP_VH
`define SPI_FAULT_MAP_VH

// status byte bit positions
`define DONE_BIT 3'h7
`define COLLISION_BIT 3'h6
`define OVERRUN_BIT 3'h5
`define FAULT_BIT 3'h4
`define FAULT_DISABLE_BIT 3'h3

// reset values of the control bits
`define MASTER_RST 1'h0
`define ENABLE_RST 1'h0
`define FAULT_DISABLE_RST 1'h0
`define SELECT_OUT_RST 1'h0

// timing: master serial clock half period, in ns and in system clocks
`define MCLK_PERIOD_NS 10
`define SCLK_HALF_NS 80
`define SCLK_HALF_CYCLES 8'h08

// bits in one serial byte
`define BYTE_BITS 4'h8

`endif

/* File: spi_rx_buffer.v */
// two-entry buffer between the receive shift register and the byte consumer
// assumes one clock domain; push and pop may occur in the same cycle
`timescale 1ns/100ps
`default_nettype none

module spi_rx_buffer
(
    // clock and reset
    input wire mclk,
    input wire sys_rst,
    // filling side
    input wire inValid,
    output wire inReady,
    input wire [7:0] inData,
    // draining side
    output wire outValid,
    input wire outReady,
    output wire [7:0] outData
);

reg [7:0] slot_ff [0:1];
reg [1:0] full_ff;
wire push;
wire pop;

assign push = inValid & ~full_ff[1];
assign pop = full_ff[0] & outReady;
assign inReady = ~full_ff[1];
assign outValid = full_ff[0];
assign outData = slot_ff[0];

////////////////////////////////////////////////////////////////////////////////
// slot 0 is the head; slot 1 moves down when the head is taken
always @(posedge mclk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        full_ff <= 2'h0;
        slot_ff[0] <= 8'h00;
        slot_ff[1] <= 8'h00;
    end
    else
    begin
        case ({push, pop})
            2'b10:
            begin
                if (!full_ff[0])
                begin
                    slot_ff[0] <= inData;
                    full_ff <= 2'h1;
                end
                else
                begin
                    slot_ff[1] <= inData;
                    full_ff <= 2'h3;
                end
            end
            2'b01:
            begin
                slot_ff[0] <= slot_ff[1];
                full_ff <= {1'b0, full_ff[1]};
            end
            2'b11:
            begin
                if (full_ff[1])
                begin
                    slot_ff[0] <= slot_ff[1];
                    slot_ff[1] <= inData;
                end
                else
                begin
                    slot_ff[0] <= inData;
                end
            end
            default:
            begin
                full_ff <= full_ff;
            end
        endcase
    end
end

endmodule // spi_rx_buffer

`default_nettype wire

/* File: spi_select_fault.v */
// select pin control, mode fault, write collision, overrun and request logic
// assumes pins come from outside the mclk domain; control is plain ports
`timescale 1ns/100ps
`default_nettype none
`include "spi_fault_map.vh"

module spi_select_fault
(
    // clock and reset
    input wire mclk,
    input wire sys_rst,
    // control writes
    input wire ctrlWr,
    input wire masterSelectIn,
    input wire portEnableIn,
    input wire faultDetectDisableIn,
    input wire selectOutputEnableIn,
    input wire serialIrqEnable,
    input wire globalIrqEnable,
    // data register write and flag clears
    input wire dataWr,
    input wire [7:0] dataWrByte,
    input wire clrDone,
    input wire clrCollision,
    input wire clrOverrun,
    input wire clrFault,
    // control and status
    output reg masterSelect_ff,
    output reg portEnable_ff,
    output reg faultDetectDisable_ff,
    output reg selectOutputEnable_ff,
    output wire [7:0] serialStatusReg,
    output reg [7:0] readBuf_ff,
    output reg irq_ff,
    // received byte stream
    output wire rxValid,
    input wire rxReady,
    output wire [7:0] rxData,
    // serial pins, enable low while driving
    input wire selectNIn,
    output reg selectNOut_ff,
    output reg selectNOeN_ff,
    input wire sclkIn,
    output reg sclkOut_ff,
    output reg sclkOeN_ff,
    input wire mosiIn,
    output reg mosiOut_ff,
    output reg mosiOeN_ff,
    input wire misoIn,
    output reg misoOut_ff,
    output reg misoOeN_ff
);

localparam ST_IDLE = 1'b0;
localparam ST_XFER = 1'b1;

reg [3:0] syncA_ff;
reg [3:0] syncB_ff;
reg ssPrev_ff;
reg sclkPrev_ff;
reg state_ff;
reg [7:0] shift_ff;
reg [3:0] bitCnt_ff;
reg [7:0] halfCnt_ff;
reg byteDone_ff;
reg doneFlag_ff;
reg collFlag_ff;
reg ovrFlag_ff;
reg faultFlag_ff;
wire ssS;
wire sclkS;
wire mosiS;
wire misoS;
wire selected;
wire faultNow;
wire busy;
wire collide;
wire loadOk;
wire storeOk;
wire bufReady;

assign ssS = syncB_ff[0];
assign sclkS = syncB_ff[1];
assign mosiS = syncB_ff[2];
assign misoS = syncB_ff[3];
// slave sees the select pin as active-low input whatever the settings
assign selected = portEnable_ff & ~masterSelect_ff & ~ssS;
// select is a fault input only when master and detection is on
assign faultNow = portEnable_ff & masterSelect_ff & ~faultDetectDisable_ff & ~ssS;
assign busy = masterSelect_ff ? (state_ff == ST_XFER) : selected;
assign collide = dataWr & busy;
assign loadOk = dataWr & ~busy;
// a byte is kept only when the last one was taken and the buffer has room
assign storeOk = byteDone_ff & ~doneFlag_ff & bufReady;
assign serialStatusReg = {doneFlag_ff, collFlag_ff, ovrFlag_ff, faultFlag_ff,
    faultDetectDisable_ff, 3'h0};

////////////////////////////////////////////////////////////////////////////////
// two-stage synchronisers for select, clock and data pins
always @(posedge mclk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        // idle pin levels: select high, clock low, so no false edge follows reset
        syncA_ff <= 4'hD;
        syncB_ff <= 4'hD;
        ssPrev_ff <= 1'b1;
        sclkPrev_ff <= 1'b0;
    end
    else
    begin
        syncA_ff <= {misoIn, mosiIn, sclkIn, selectNIn};
        syncB_ff <= syncA_ff;
        ssPrev_ff <= ssS;
        sclkPrev_ff <= sclkS;
    end
end

////////////////////////////////////////////////////////////////////////////////
// control bits; a mode fault overrides a software write of the master and enable bits
always @(posedge mclk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        masterSelect_ff <= `MASTER_RST;
        portEnable_ff <= `ENABLE_RST;
        faultDetectDisable_ff <= `FAULT_DISABLE_RST;
        selectOutputEnable_ff <= `SELECT_OUT_RST;
    end
    else
    begin
        if (ctrlWr)
        begin
            faultDetectDisable_ff <= faultDetectDisableIn;
            selectOutputEnable_ff <= selectOutputEnableIn;
        end
        if (faultNow)
        begin
            masterSelect_ff <= 1'b0;
            portEnable_ff <= 1'b0;
        end
        else if (ctrlWr)
        begin
            masterSelect_ff <= masterSelectIn;
            portEnable_ff <= portEnableIn;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// shift engine: mode 0, msb first; master makes the clock, slave follows it
always @(posedge mclk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        state_ff <= ST_IDLE;
        shift_ff <= 8'h00;
        bitCnt_ff <= 4'h0;
        halfCnt_ff <= 8'h00;
        byteDone_ff <= 1'b0;
        sclkOut_ff <= 1'b0;
        mosiOut_ff <= 1'b0;
        misoOut_ff <= 1'b0;
    end
    else
    begin
        byteDone_ff <= 1'b0;
        if (loadOk)
        begin
            shift_ff <= dataWrByte;
            mosiOut_ff <= dataWrByte[7];
            misoOut_ff <= dataWrByte[7];
        end
        if (faultNow || !portEnable_ff)
        begin
            state_ff <= ST_IDLE;
            sclkOut_ff <= 1'b0;
            bitCnt_ff <= 4'h0;
        end
        else if (masterSelect_ff)
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    if (loadOk)
                    begin
                        state_ff <= ST_XFER;
                        halfCnt_ff <= `SCLK_HALF_CYCLES - 8'h01;
                        bitCnt_ff <= 4'h0;
                    end
                end
                ST_XFER:
                begin
                    if (halfCnt_ff != 8'h00)
                    begin
                        halfCnt_ff <= halfCnt_ff - 8'h01;
                    end
                    else if (!sclkOut_ff)
                    begin
                        halfCnt_ff <= `SCLK_HALF_CYCLES - 8'h01;
                        sclkOut_ff <= 1'b1;
                        shift_ff <= {shift_ff[6:0], misoS};
                        bitCnt_ff <= bitCnt_ff + 4'h1;
                    end
                    else
                    begin
                        halfCnt_ff <= `SCLK_HALF_CYCLES - 8'h01;
                        sclkOut_ff <= 1'b0;
                        mosiOut_ff <= shift_ff[7];
                        if (bitCnt_ff == `BYTE_BITS)
                        begin
                            state_ff <= ST_IDLE;
                            byteDone_ff <= 1'b1;
                        end
                    end
                end
                default:
                begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
        else
        begin
            state_ff <= ST_IDLE;
            if (!selected)
            begin
                bitCnt_ff <= 4'h0;
            end
            else if (ssPrev_ff)
            begin
                misoOut_ff <= shift_ff[7];
                bitCnt_ff <= 4'h0;
            end
            else if (sclkS && !sclkPrev_ff)
            begin
                shift_ff <= {shift_ff[6:0], mosiS};
                if (bitCnt_ff == `BYTE_BITS - 4'h1)
                begin
                    bitCnt_ff <= 4'h0;
                    byteDone_ff <= 1'b1;
                end
                else
                begin
                    bitCnt_ff <= bitCnt_ff + 4'h1;
                end
            end
            else if (!sclkS && sclkPrev_ff)
            begin
                misoOut_ff <= shift_ff[7];
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// pin drivers for select, clock and data lines
always @(posedge mclk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        selectNOut_ff <= 1'b1;
        selectNOeN_ff <= 1'b1;
        sclkOeN_ff <= 1'b1;
        mosiOeN_ff <= 1'b1;
        misoOeN_ff <= 1'b1;
    end
    else
    begin
        // drive select only as master with detection off and output on
        selectNOeN_ff <= ~(portEnable_ff & masterSelect_ff & faultDetectDisable_ff
            & selectOutputEnable_ff);
        selectNOut_ff <= ~(state_ff == ST_XFER);
        sclkOeN_ff <= ~(portEnable_ff & masterSelect_ff);
        mosiOeN_ff <= ~(portEnable_ff & masterSelect_ff);
        misoOeN_ff <= ~selected;
    end
end

////////////////////////////////////////////////////////////////////////////////
// read buffer and sticky flags; a set wins over a clear in the same cycle
always @(posedge mclk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        readBuf_ff <= 8'h00;
        doneFlag_ff <= 1'b0;
        collFlag_ff <= 1'b0;
        ovrFlag_ff <= 1'b0;
        faultFlag_ff <= 1'b0;
        irq_ff <= 1'b0;
    end
    else
    begin
        if (storeOk)
        begin
            readBuf_ff <= shift_ff;
        end
        // flags stay until software clears them
        doneFlag_ff <= storeOk | (doneFlag_ff & ~clrDone);
        collFlag_ff <= collide | (collFlag_ff & ~clrCollision);
        ovrFlag_ff <= (byteDone_ff & ~storeOk) | (ovrFlag_ff & ~clrOverrun);
        faultFlag_ff <= faultNow | (faultFlag_ff & ~clrFault);
        // one shared level request from the three flags
        irq_ff <= (doneFlag_ff | ovrFlag_ff | faultFlag_ff)
            & serialIrqEnable & globalIrqEnable;
    end
end

////////////////////////////////////////////////////////////////////////////////
// received bytes also flow to the consumer through a two-entry buffer
spi_rx_buffer rxBuffer
(
    .mclk(mclk),
    .sys_rst(sys_rst),
    .inValid(storeOk),
    .inReady(bufReady),
    .inData(shift_ff),
    .outValid(rxValid),
    .outReady(rxReady),
    .outData(rxData)
);

endmodule // spi_select_fault

`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the select, fault and error logic
// assumes the far end model, the checker and the design are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "spi_fault_map.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("ERROR %0t got %h exp %h", $time, a, e); end end
module testbench;
    logic mclk, sys_rst, ctrlWr, masterSelectIn, portEnableIn, faultDetectDisableIn;
    logic selectOutputEnableIn, serialIrqEnable, globalIrqEnable, dataWr, rxReady;
    logic clrDone, clrCollision, clrOverrun, clrFault, irq_ff, rxValid;
    logic masterSelect_ff, portEnable_ff, faultDetectDisable_ff, selectOutputEnable_ff;
    logic selectNOut_ff, selectNOeN_ff, sclkOut_ff, sclkOeN_ff, mosiOut_ff, mosiOeN_ff;
    logic misoOut_ff, misoOeN_ff, sOut, mSelN, mSclk, mMosi;
    logic [7:0] dataWrByte, serialStatusReg, readBuf_ff, rxData;
    int n_checks = 0;
    int n_mismatch = 0;
    // wire levels from all parties' enables
    wire logic selW = selectNOeN_ff ? mSelN : selectNOut_ff;
    wire logic sclkW = sclkOeN_ff ? mSclk : sclkOut_ff;
    wire logic mosiW = mosiOeN_ff ? mMosi : mosiOut_ff;
    wire logic misoW = misoOeN_ff ? sOut : misoOut_ff;
    spi_select_fault DUT
    (
        .mclk, .sys_rst, .ctrlWr, .masterSelectIn, .portEnableIn, .faultDetectDisableIn,
        .selectOutputEnableIn, .serialIrqEnable, .globalIrqEnable, .dataWr, .dataWrByte,
        .clrDone, .clrCollision, .clrOverrun, .clrFault, .masterSelect_ff, .portEnable_ff,
        .faultDetectDisable_ff, .selectOutputEnable_ff, .serialStatusReg, .readBuf_ff, .irq_ff,
        .rxValid, .rxReady, .rxData, .selectNIn(selW), .selectNOut_ff, .selectNOeN_ff,
        .sclkIn(sclkW), .sclkOut_ff, .sclkOeN_ff, .mosiIn(mosiW), .mosiOut_ff, .mosiOeN_ff,
        .misoIn(misoW), .misoOut_ff, .misoOeN_ff
    );
    spi_far_end P
    (
        .selN(selW), .sclk(sclkW), .mosi(mosiW), .miso(misoW), .sOut, .mSelN, .mSclk, .mMosi
    );
    ////////////////////////////////////////////////////////////////////////////////
    // every drive lands 1 ns after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic ctl(input logic [3:0] c);
        {masterSelectIn, portEnableIn, faultDetectDisableIn, selectOutputEnableIn} = c;
        ctrlWr = 1'b1;
        tick(1);
        ctrlWr = 1'b0;
        tick(2);
    endtask
    task automatic wr(input logic [7:0] b);
        dataWrByte = b;
        dataWr = 1'b1;
        tick(1);
        dataWr = 1'b0;
        tick(1);
    endtask
    task automatic clr(input logic [3:0] c);
        {clrDone, clrCollision, clrOverrun, clrFault} = c;
        tick(1);
        {clrDone, clrCollision, clrOverrun, clrFault} = 4'h0;
        tick(2);
    endtask
    // one master byte: sixteen half periods plus margin
    task automatic xfer(input logic [7:0] tx, input logic [7:0] b);
        P.txByte = tx;
        wr(b);
        tick(`SCLK_HALF_CYCLES * 16 + 8);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // system clock
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // tests take about 10 us, so a hang is cut at 60 us
    initial
    begin
        #60000;
        n_mismatch++;
        stop_test;
    end
    // test sequence
    initial
    begin
        {ctrlWr, masterSelectIn, portEnableIn, faultDetectDisableIn} = 4'h0;
        {selectOutputEnableIn, dataWr, rxReady, clrDone, clrCollision} = 5'h00;
        {clrOverrun, clrFault, dataWrByte} = 10'h000;
        {serialIrqEnable, globalIrqEnable, sys_rst} = 3'h7;
        tick(5);
        sys_rst = 1'b0;
        `CHK(serialStatusReg, 8'h00)
        `CHK({irq_ff, rxValid, selectNOeN_ff, masterSelect_ff, portEnable_ff}, 5'h04)
        $display("test reset done");
        ctl(4'hF);
        `CHK({sclkOeN_ff, mosiOeN_ff, misoOeN_ff, selectOutputEnable_ff}, 4'h3)
        P.txByte = 8'h3C;
        wr(8'hA5);
        tick(20);
        `CHK(selW, 1'b0)
        wr(8'h11);
        tick(120);
        `CHK(selW, 1'b1)
        `CHK(readBuf_ff, 8'h3C)
        `CHK(P.rxByte, 8'hA5)
        `CHK(serialStatusReg, 8'hC8)
        `CHK(irq_ff, 1'b1)
        globalIrqEnable = 1'b0;
        tick(2);
        `CHK(irq_ff, 1'b0)
        globalIrqEnable = 1'b1;
        clr(4'h4);
        `CHK(serialStatusReg, 8'h88)
        $display("test master done");
        xfer(8'h96, 8'h01);
        `CHK(readBuf_ff, 8'h3C)
        `CHK(serialStatusReg[5], 1'b1)
        clr(4'hA);
        xfer(8'h69, 8'h02);
        `CHK(readBuf_ff, 8'h69)
        clr(4'hA);
        xfer(8'h5A, 8'h03);
        `CHK({readBuf_ff, serialStatusReg[5]}, 9'h0D3)
        `CHK(rxData, 8'h3C)
        rxReady = 1'b1;
        tick(1);
        `CHK(rxData, 8'h69)
        tick(1);
        `CHK(rxValid, 1'b0)
        rxReady = 1'b0;
        clr(4'hF);
        $display("test overrun done");
        ctl(4'hC);
        wr(8'h77);
        tick(30);
        P.mSelN = 1'b0;
        tick(8);
        `CHK({masterSelect_ff, portEnable_ff, serialStatusReg[4], sclkOut_ff}, 4'h2)
        `CHK(irq_ff, 1'b1)
        `CHK(serialStatusReg[7:4], 4'h1)
        tick(150);
        `CHK(serialStatusReg[7], 1'b0)
        P.mSelN = 1'b1;
        clr(4'h1);
        `CHK(irq_ff, 1'b0)
        $display("test fault done");
        ctl(4'h7);
        wr(8'hC3);
        P.xfer(8'h5A);
        tick(10);
        `CHK(readBuf_ff, 8'h5A)
        `CHK(P.rxByte, 8'hC3)
        P.mSelN = 1'b0;
        tick(4);
        wr(8'hFF);
        `CHK({serialStatusReg[6], selectNOeN_ff}, 2'h3)
        `CHK({sclkOeN_ff, mosiOeN_ff, misoOeN_ff}, 3'h6)
        P.mSelN = 1'b1;
        $display("test slave done");
        stop_test;
    end
endmodule // testbench
`default_nettype wire
